// File: logic/fault_seq_pkg.sv
// shared constants and types of the fault supervisor and retry sequencer
package fault_seq_pkg;
   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned TICK_PERIOD_US = 1000;
   localparam int unsigned MS_TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_PERIOD_US;
   localparam logic [7:0] SOFT_START_MS = 8'h32;       // 50 ms
   localparam logic [7:0] OCP_PERSIST_MS = 8'h32;      // 50 ms
   localparam logic [7:0] RESTART_DEFAULT_MS = 8'h64;  // 100 ms
   localparam logic [7:0] RESTART_MIN_MS = 8'h0a;      // 10 ms
   localparam logic [7:0] RESTART_MAX_MS = 8'hc8;      // 200 ms
   localparam logic [3:0] RETRY_LIMIT_DEFAULT = 4'h8;
   localparam logic [3:0] RETRY_SAT = 4'hf;
   // ----------------------------------------------------------------
   // rails, in power-up order
   // ----------------------------------------------------------------
   localparam int NUM_RAILS = 4;
   localparam logic [1:0] RAIL_ANALOG_SUPPLY = 2'h0;
   localparam logic [1:0] RAIL_GATE_LOW = 2'h1;
   localparam logic [1:0] RAIL_GATE_HIGH = 2'h2;
   localparam logic [1:0] RAIL_BACKPLANE = 2'h3;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_RESTART = 8'h04;
   localparam logic [7:0] OFS_RETRY = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_CAUSE = 8'h10;
   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RESET = 1'b0;
   localparam int ST_STATE_LSB = 0;
   localparam int ST_COUNT_LSB = 4;
   localparam int ST_LOCK_BIT = 8;
   localparam int ST_FAULT_BIT = 9;
   localparam int ST_OSC_BIT = 10;
   localparam int ST_PIN_BIT = 11;
   localparam int CAUSE_START = 0;
   localparam int CAUSE_UNDER = 1;
   localparam int CAUSE_OVER = 2;
   localparam int CAUSE_OCP = 3;
   localparam int CAUSE_FREQUENCY_SET_PIN = 4;
   localparam int CAUSE_SW_OV = 5;
   localparam int CAUSE_SW_ILIM2 = 6;
   localparam int CAUSE_THERMAL = 7;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   // ----------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      S_OFF, S_IDLE, S_UP, S_RUN, S_DOWN, S_RESTART, S_LOCK
   } state_t;
endpackage : fault_seq_pkg

// File: logic/tick_prescaler.sv
// millisecond tick enable derived from the system clock
`timescale 1ns/1ps
module tick_prescaler #(
   parameter int unsigned CYCLES = 50000
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // tick
   output logic tick_o
);
   logic [31:0] count_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_q <= 32'h0;
         tick_o <= 1'b0;
      end else if (count_q == 32'(CYCLES - 1)) begin
         count_q <= 32'h0;
         tick_o <= 1'b1;
      end else begin
         count_q <= count_q + 32'h1;
         tick_o <= 1'b0;
      end
   end
endmodule : tick_prescaler

// File: logic/interval_timer.sv
// tick counter that flags when a programmed interval has elapsed
`timescale 1ns/1ps
module interval_timer (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // control
   input wire logic tick_i,
   input wire logic clear_i,
   input wire logic [7:0] limit_i,
   // status
   output logic done_o
);
   logic [7:0] count_q;

   // saturates so a stuck condition never wraps back to "not yet"
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_q <= 8'h0;
      end else if (clear_i) begin
         count_q <= 8'h0;
      end else if (tick_i && count_q != 8'hff) begin
         count_q <= count_q + 8'h1;
      end
   end

   assign done_o = (count_q >= limit_i);
endmodule : interval_timer

// File: logic/fault_supervisor_retry_sequencer.sv
// rail sequencer with fault classification, restart delay and retry lockout
//
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
// Function
// - stay off until supplies clear lockout
// - enable rails analog, gate-low, gate-high, backplane
// - monitor faults in all phases, startup masks apply
// - startup timeout: fault low, sequenced shutdown
// - under 80% after startup: sequenced shutdown, retry
// - over 120%: rail off now, rest sequenced
// - overcurrent tolerated until 50 ms persistence
// - frequency pin short: internal oscillator, sequenced shutdown
// - wait restart delay before new startup
// - retry limit reached: lockout until enable low
// - switch overvoltage, thermal, 150% current: immediate off
// - supply loss: immediate off, erase, no fault
// - supply loss clears retry counter
// - fault output low through restart delay
// - counter cleared by enable-low shutdown or power
// - restart delay 10-200 ms, retry limit 0-15
// - soft-start timeout is 50 ms
module fault_supervisor_retry_sequencer import fault_seq_pkg::*; #(
   parameter int unsigned TICK_CYCLES = MS_TICK_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // ahb-lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   // supplies and host enable
   input wire logic vin_ok_i,
   input wire logic bias_ok_i,
   input wire logic enable_pin_i,
   // rail monitors, bit order analog, gate-low, gate-high, backplane
   input wire logic [NUM_RAILS-1:0] rail_good90_i,
   input wire logic [NUM_RAILS-1:0] rail_under80_i,
   input wire logic [NUM_RAILS-1:0] rail_over120_i,
   input wire logic [NUM_RAILS-1:0] rail_ilim_i,
   // device-level monitors
   input wire logic frequency_set_pin_short_i,
   input wire logic switch_overvoltage_i,
   input wire logic switch_second_current_limit_i,
   input wire logic thermal_trip_i,
   // rail enables and oscillator select
   output logic [NUM_RAILS-1:0] rail_en_o,
   output logic osc_internal_o,
   // open-drain fault pin
   input wire logic fault_pin_i,
   output logic fault_pin_o,
   output logic fault_pin_oe_o
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   state_t state_q;
   logic [NUM_RAILS-1:0] rail_en_q;
   logic [1:0] idx_q;
   logic [1:0] down_idx_q;
   logic [3:0] cnt_q;
   logic [3:0] cnt_inc;
   logic fault_q;
   logic osc_q;
   logic down_fault_q;
   logic ss_clr_q;
   logic dly_clr_q;
   logic ctrl_en_q;
   logic [7:0] restart_ms_q;
   logic [3:0] retry_limit_q;
   logic [7:0] cause_q;
   logic [7:0] cause_set;
   logic tick;
   logic ss_done;
   logic ocp_done;
   logic ocp_clr;
   logic dly_done;
   logic supply_loss;
   logic go;
   logic up_or_run;
   logic class2;
   logic start_fail;
   logic uv;
   logic ov;
   logic ocp;
   logic frequency_set_pin_f;
   logic class1;
   logic ap_valid;
   logic dp_wr_q;
   logic [7:0] dp_addr_q;
   logic [31:0] rd_data;
   logic [31:0] hrdata_q;
   logic [7:0] wr_ms;

   // ----------------------------------------------------------------
   // timers
   // ----------------------------------------------------------------
   tick_prescaler #(.CYCLES(TICK_CYCLES)) u_tick (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .tick_o(tick)
   );

   // each interval restarts from zero at its own start
   interval_timer u_soft_start (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .tick_i(tick),
      .clear_i(ss_clr_q),
      .limit_i(SOFT_START_MS),
      .done_o(ss_done)
   );

   assign ocp_clr = (state_q != S_RUN) || (rail_ilim_i == '0);
   interval_timer u_ocp (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .tick_i(tick),
      .clear_i(ocp_clr),
      .limit_i(OCP_PERSIST_MS),
      .done_o(ocp_done)
   );

   interval_timer u_restart (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .tick_i(tick),
      .clear_i(dly_clr_q),
      .limit_i(restart_ms_q),
      .done_o(dly_done)
   );

   // ----------------------------------------------------------------
   // fault classification
   // ----------------------------------------------------------------
   assign supply_loss = !vin_ok_i || !bias_ok_i;
   assign go = enable_pin_i && ctrl_en_q;
   assign up_or_run = (state_q == S_UP) || (state_q == S_RUN);
   // immediate class is watched in every active phase, shutdown included
   assign class2 = (up_or_run || state_q == S_DOWN) && (switch_overvoltage_i
                   || switch_second_current_limit_i || thermal_trip_i);
   // a just-cleared soft-start timer still shows the old count, hence the gate
   assign start_fail = (state_q == S_UP) && !ss_clr_q && ss_done
                       && !rail_good90_i[idx_q];
   assign uv = (state_q == S_RUN) && (rail_under80_i != '0);
   assign ov = (state_q == S_RUN) && (rail_over120_i != '0);
   assign ocp = (state_q == S_RUN) && ocp_done;
   assign frequency_set_pin_f = up_or_run && frequency_set_pin_short_i;
   assign class1 = start_fail || uv || ov || ocp || frequency_set_pin_f;
   assign cnt_inc = (cnt_q == RETRY_SAT) ? cnt_q : cnt_q + 4'h1;

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= S_OFF;
         rail_en_q <= '0;
         idx_q <= 2'h0;
         down_idx_q <= 2'h0;
         cnt_q <= 4'h0;
         fault_q <= 1'b0;
         osc_q <= 1'b0;
         down_fault_q <= 1'b0;
         ss_clr_q <= 1'b1;
         dly_clr_q <= 1'b1;
      end else if (supply_loss) begin
         // highest severity: erase everything, no fault flag, no retry
         state_q <= S_OFF;
         rail_en_q <= '0;
         cnt_q <= 4'h0;
         fault_q <= 1'b0;
         osc_q <= 1'b0;
         down_fault_q <= 1'b0;
         ss_clr_q <= 1'b1;
         dly_clr_q <= 1'b1;
      end else if (class2) begin
         rail_en_q <= '0;
         fault_q <= 1'b1;
         cnt_q <= cnt_inc;
         dly_clr_q <= 1'b1;
         state_q <= (cnt_inc >= retry_limit_q) ? S_LOCK : S_RESTART;
      end else if (class1) begin
         rail_en_q <= rail_en_q & ~(ov ? rail_over120_i : '0);
         fault_q <= 1'b1;
         cnt_q <= cnt_inc;
         if (frequency_set_pin_f) begin
            osc_q <= 1'b1;
         end
         down_fault_q <= 1'b1;
         down_idx_q <= RAIL_BACKPLANE;
         state_q <= S_DOWN;
      end else begin
         ss_clr_q <= 1'b0;
         dly_clr_q <= 1'b0;
         case (state_q)
            S_OFF: begin
               state_q <= S_IDLE;
            end
            S_IDLE: begin
               if (go) begin
                  state_q <= S_UP;
                  idx_q <= RAIL_ANALOG_SUPPLY;
                  rail_en_q <= '0;
                  rail_en_q[RAIL_ANALOG_SUPPLY] <= 1'b1;
                  ss_clr_q <= 1'b1;
               end
            end
            S_UP, S_RUN: begin
               if (!go) begin
                  down_fault_q <= 1'b0;
                  down_idx_q <= RAIL_BACKPLANE;
                  state_q <= S_DOWN;
               end else if (state_q == S_UP && !ss_clr_q && rail_good90_i[idx_q]) begin
                  if (idx_q == RAIL_BACKPLANE) begin
                     state_q <= S_RUN;
                  end else begin
                     idx_q <= idx_q + 2'h1;
                     rail_en_q[2'(idx_q + 2'h1)] <= 1'b1;
                     ss_clr_q <= 1'b1;
                  end
               end
            end
            S_DOWN: begin
               // one rail per tick, reverse of power-up order
               if (tick) begin
                  rail_en_q[down_idx_q] <= 1'b0;
                  if (down_idx_q == RAIL_ANALOG_SUPPLY) begin
                     if (!down_fault_q) begin
                        cnt_q <= 4'h0;
                        state_q <= S_IDLE;
                     end else if (cnt_q >= retry_limit_q) begin
                        state_q <= S_LOCK;
                     end else begin
                        dly_clr_q <= 1'b1;
                        state_q <= S_RESTART;
                     end
                  end else begin
                     down_idx_q <= down_idx_q - 2'h1;
                  end
               end
            end
            S_RESTART: begin
               if (!dly_clr_q && dly_done) begin
                  fault_q <= 1'b0;
                  state_q <= S_IDLE;
               end
            end
            S_LOCK: begin
               if (!enable_pin_i) begin
                  fault_q <= 1'b0;
                  cnt_q <= 4'h0;
                  state_q <= S_IDLE;
               end
            end
            default: begin
               state_q <= S_OFF;
            end
         endcase
      end
   end

   assign rail_en_o = rail_en_q;
   assign osc_internal_o = osc_q;
   assign fault_pin_o = 1'b0;
   assign fault_pin_oe_o = fault_q;

   // ----------------------------------------------------------------
   // fault cause record, hardware set beats software clear
   // ----------------------------------------------------------------
   assign cause_set = {
      class2 && thermal_trip_i, class2 && switch_second_current_limit_i,
      class2 && switch_overvoltage_i, frequency_set_pin_f, ocp, ov, uv, start_fail};

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cause_q <= 8'h0;
      end else if (supply_loss) begin
         cause_q <= 8'h0;
      end else if (dp_wr_q && dp_addr_q == OFS_CAUSE) begin
         cause_q <= (cause_q & ~hwdata_i[7:0]) | cause_set;
      end else begin
         cause_q <= cause_q | cause_set;
      end
   end

   // ----------------------------------------------------------------
   // ahb-lite slave, zero wait states
   // ----------------------------------------------------------------
   assign ap_valid = hsel_i && htrans_i[1] && hready_i;
   assign wr_ms = (hwdata_i[7:0] < RESTART_MIN_MS) ? RESTART_MIN_MS :
                  (hwdata_i[7:0] > RESTART_MAX_MS) ? RESTART_MAX_MS : hwdata_i[7:0];

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dp_wr_q <= 1'b0;
         dp_addr_q <= 8'h0;
      end else begin
         dp_wr_q <= ap_valid && hwrite_i && hsize_i == HSIZE_WORD;
         dp_addr_q <= haddr_i[7:0];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_en_q <= CTRL_EN_RESET;
         restart_ms_q <= RESTART_DEFAULT_MS;
         retry_limit_q <= RETRY_LIMIT_DEFAULT;
      end else if (supply_loss) begin
         ctrl_en_q <= CTRL_EN_RESET;
         restart_ms_q <= RESTART_DEFAULT_MS;
         retry_limit_q <= RETRY_LIMIT_DEFAULT;
      end else if (dp_wr_q) begin
         case (dp_addr_q)
            OFS_CTRL: ctrl_en_q <= hwdata_i[CTRL_EN_BIT];
            OFS_RESTART: restart_ms_q <= wr_ms;
            OFS_RETRY: retry_limit_q <= hwdata_i[3:0];
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      rd_data = 32'h0;
      case (haddr_i[7:0])
         OFS_CTRL: rd_data[CTRL_EN_BIT] = ctrl_en_q;
         OFS_RESTART: rd_data[7:0] = restart_ms_q;
         OFS_RETRY: rd_data[3:0] = retry_limit_q;
         OFS_STATUS: begin
            rd_data[ST_STATE_LSB +: 3] = state_q;
            rd_data[ST_COUNT_LSB +: 4] = cnt_q;
            rd_data[ST_LOCK_BIT] = (state_q == S_LOCK);
            rd_data[ST_FAULT_BIT] = fault_q;
            rd_data[ST_OSC_BIT] = osc_q;
            rd_data[ST_PIN_BIT] = fault_pin_i;
         end
         OFS_CAUSE: rd_data[7:0] = cause_q;
         default: rd_data = 32'h0;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hrdata_q <= 32'h0;
      end else if (ap_valid && !hwrite_i) begin
         hrdata_q <= rd_data;
      end
   end

   assign hrdata_o = hrdata_q;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence seq_run_under;
      state_q == S_RUN && uv && !ov && !supply_loss && !class2;
   endsequence

   sequence seq_enter_down;
      state_q == S_DOWN && fault_pin_oe_o;
   endsequence

   supply_erase_a:
      assert property (supply_loss |=> state_q == S_OFF && rail_en_o == '0
                       && cnt_q == 4'h0 && !fault_pin_oe_o)
      else $error("supply loss did not erase state");
   order_up_a:
      assert property (state_q == S_UP |-> rail_en_o inside {4'h1, 4'h3, 4'h7, 4'hf})
      else $error("rails out of power-up order");
   start_fail_a:
      assert property (start_fail && !supply_loss && !class2 |=> seq_enter_down)
      else $error("startup timeout not handled");
   under_trip_a:
      assert property (seq_run_under |=> seq_enter_down and (cnt_q == $past(cnt_inc)))
      else $error("undervoltage not handled");
   over_cut_a:
      assert property (ov && !supply_loss && !class2
                       |=> (rail_en_o & $past(rail_over120_i)) == '0)
      else $error("overvoltage rail not cut at once");
   ocp_wait_a:
      assert property (state_q == S_RUN && go && !ocp_done && !uv && !ov
                       && !frequency_set_pin_f && !class2 && !supply_loss |=> state_q == S_RUN)
      else $error("overcurrent tripped early");
   startup_mask_a:
      assert property (state_q == S_UP && go && !start_fail && !frequency_set_pin_f && !class2
                       && !supply_loss |=> state_q inside {S_UP, S_RUN})
      else $error("masked check acted during startup");
   frequency_set_pin_osc_a:
      assert property (frequency_set_pin_f && !supply_loss && !class2
                       |=> seq_enter_down and osc_internal_o)
      else $error("frequency pin short not handled");
   immediate_off_a:
      assert property (class2 && !supply_loss
                       |=> rail_en_o == '0 && fault_pin_oe_o && state_q != S_DOWN)
      else $error("immediate class not immediate");
   restart_hold_a:
      assert property (state_q == S_RESTART |-> fault_pin_oe_o && rail_en_o == '0)
      else $error("fault pin released during restart delay");
   lock_hold_a:
      assert property (state_q == S_LOCK && enable_pin_i && !supply_loss
                       |=> state_q == S_LOCK && rail_en_o == '0)
      else $error("lockout left while enabled");
   delay_range_a:
      assert property (restart_ms_q >= RESTART_MIN_MS && restart_ms_q <= RESTART_MAX_MS)
      else $error("restart delay out of range");
endmodule : fault_supervisor_retry_sequencer

// File: bench/rail_monitor_model.sv
// far-side rail monitor model: an enabled rail reports good after its rise time
`timescale 1ns/1ps
module rail_monitor_model #(
   parameter int unsigned RISE = 20
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // rail enables and injected stuck rails
   input wire logic [3:0] rail_en_i,
   input wire logic [3:0] stuck_i,
   // good indications
   output logic [3:0] good90_o
);
   logic [7:0] age_q [4];
   // later rails rise slower, so both quick and slow answers occur
   for (genvar i = 0; i < 4; i++) begin : g_rail
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) age_q[i] <= 8'h00;
         else if (!rail_en_i[i]) age_q[i] <= 8'h00;
         else if (age_q[i] != 8'hff) age_q[i] <= age_q[i] + 8'h01;
      end
      // a disabled rail reads not good at once, never its last value
      assign good90_o[i] = rail_en_i[i] & ~stuck_i[i] & (age_q[i] >= 8'(RISE + 16 * i));
   end
endmodule : rail_monitor_model

// File: bench/fault_supervisor_retry_sequencer_bench.sv
// self-checking bench for the fault supervisor and retry sequencer
`timescale 1ns/1ps
module fault_supervisor_retry_sequencer_bench;
   import fault_seq_pkg::*;
   // ----
   // signals
   // ----
   typedef struct packed {
      logic wr;
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] e;
   } row_t;
   localparam row_t ROWS [11] = '{
      '{1'b0, OFS_CTRL, 32'h0, 32'h0},
      '{1'b0, OFS_RESTART, 32'h0, 32'h64},
      '{1'b0, OFS_RETRY, 32'h0, 32'h8},
      '{1'b0, OFS_STATUS, 32'h0, 32'h801},
      '{1'b0, OFS_CAUSE, 32'h0, 32'h0},
      '{1'b1, OFS_RESTART, 32'h5, 32'ha},
      '{1'b1, OFS_RESTART, 32'hfa, 32'hc8},
      '{1'b1, OFS_RESTART, 32'ha, 32'ha},
      '{1'b1, OFS_RETRY, 32'hf, 32'hf},
      '{1'b1, 8'h20, 32'h5a, 32'h0},
      '{1'b1, OFS_CTRL, 32'h1, 32'h1}};
   logic clk_i, rst_n_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0, hready_i;
   logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, rd;
   logic [1:0] htrans_i = 2'h0;
   logic [2:0] hsize_i = HSIZE_WORD;
   logic vin_ok_i = 1'b1, bias_ok_i = 1'b1, enable_pin_i = 1'b1, hreadyout_o, hresp_o;
   logic [3:0] rail_good90_i, rail_under80_i = 4'h0, rail_over120_i = 4'h0;
   logic [3:0] rail_ilim_i = 4'h0, stuck = 4'h0, rail_en_o;
   logic frequency_set_pin_short_i = 1'b0, switch_overvoltage_i = 1'b0;
   logic switch_second_current_limit_i = 1'b0, thermal_trip_i = 1'b0;
   logic osc_internal_o, fault_pin_i, fault_pin_o, fault_pin_oe_o;
   int errors, samples_checked, c;
   // the fault wire has a pull-up; the hready of the bus is the one slave's
   assign fault_pin_i = fault_pin_oe_o ? fault_pin_o : 1'b1;
   assign hready_i = hreadyout_o;
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // ----
   // design and far side
   // ----
   fault_supervisor_retry_sequencer #(.TICK_CYCLES(10)) u_fault_supervisor_retry_sequencer (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
      .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .hrdata_o(hrdata_o), .vin_ok_i(vin_ok_i), .bias_ok_i(bias_ok_i),
      .enable_pin_i(enable_pin_i), .rail_good90_i(rail_good90_i),
      .rail_under80_i(rail_under80_i), .rail_over120_i(rail_over120_i),
      .rail_ilim_i(rail_ilim_i), .frequency_set_pin_short_i(frequency_set_pin_short_i),
      .switch_overvoltage_i(switch_overvoltage_i), .thermal_trip_i(thermal_trip_i),
      .switch_second_current_limit_i(switch_second_current_limit_i),
      .rail_en_o(rail_en_o), .osc_internal_o(osc_internal_o), .fault_pin_i(fault_pin_i),
      .fault_pin_o(fault_pin_o), .fault_pin_oe_o(fault_pin_oe_o));
   rail_monitor_model #(.RISE(20)) u_rail_monitor_model (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .rail_en_i(rail_en_o), .stuck_i(stuck),
      .good90_o(rail_good90_i));
   // ----
   // bus and check tasks
   // ----
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk_i);
      hsel_i <= 1'b1;
      haddr_i <= {24'h0, a};
      hwrite_i <= wr;
      htrans_i <= 2'h2;
      @(posedge clk_i);
      while (hready_i !== 1'b1) @(posedge clk_i);
      htrans_i <= 2'h0;
      hsel_i <= 1'b0;
      hwdata_i <= wd;
      @(posedge clk_i);
      while (hready_i !== 1'b1) @(posedge clk_i);
      rd = hrdata_o;
   endtask : ahb
   task automatic wait_en(input logic [3:0] v);
      for (int k = 0; k < 2000 && rail_en_o !== v; k++) @(negedge clk_i);
      chk("rail_en", 32'(v), 32'(rail_en_o));
   endtask : wait_en
   task automatic run_up();
      for (int i = 1; i <= 4; i++) wait_en(4'((1 << i) - 1));
      // the backplane rail needs its rise time before the run state is reached
      repeat (80) @(negedge clk_i);
      ahb(1'b0, OFS_STATUS, 32'h0);
      chk("state", 32'h3, 32'(rd[2:0]));
   endtask : run_up
   // restart delay is 10 ticks of 10 cycles; the tick runs free
   task automatic recover();
      wait_en(4'h0);
      for (c = 0; c < 5000 && fault_pin_oe_o === 1'b1; c++) @(negedge clk_i);
      chk("hold", 32'h1, 32'(c >= 85 && c <= 115));
      run_up();
   endtask : recover
   task automatic wrap_up();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (60000) @(posedge clk_i);
      errors++;
      wrap_up();
   end
   // ----
   // sequence
   // ----
   initial begin
      repeat (20) @(posedge clk_i);
      chk("reset", 32'h0, 32'({rail_en_o, fault_pin_oe_o}));
      rst_n_i <= 1'b1;
      for (int i = 0; i < 11; i++) begin
         if (ROWS[i].wr) ahb(1'b1, ROWS[i].a, ROWS[i].d);
         ahb(1'b0, ROWS[i].a, 32'h0);
         chk("reg", ROWS[i].e, rd);
         chk("resp", 32'h0, 32'({hresp_o, ~hreadyout_o, fault_pin_o}));
      end
      run_up();
      @(posedge clk_i);
      rail_under80_i <= 4'h8;
      @(posedge clk_i);
      rail_under80_i <= 4'h0;
      @(negedge clk_i);
      chk("fault", 32'h1f, 32'({rail_en_o, fault_pin_oe_o}));
      wait_en(4'h7);
      wait_en(4'h3);
      wait_en(4'h1);
      recover();
      @(posedge clk_i);
      thermal_trip_i <= 1'b1;
      rail_under80_i <= 4'h1;
      @(posedge clk_i);
      thermal_trip_i <= 1'b0;
      rail_under80_i <= 4'h0;
      @(negedge clk_i);
      chk("rail_en", 32'h0, 32'(rail_en_o));
      recover();
      @(posedge clk_i);
      rail_over120_i <= 4'h2;
      @(posedge clk_i);
      rail_over120_i <= 4'h0;
      @(negedge clk_i);
      chk("rail_en", 32'hd, 32'(rail_en_o));
      recover();
      @(posedge clk_i);
      rail_ilim_i <= 4'h1;
      repeat (300) @(posedge clk_i);
      rail_ilim_i <= 4'h0;
      @(posedge clk_i);
      rail_ilim_i <= 4'h1;
      repeat (300) @(posedge clk_i);
      chk("fault", 32'h0, 32'(fault_pin_oe_o));
      for (c = 0; c < 300 && fault_pin_oe_o !== 1'b1; c++) @(negedge clk_i);
      chk("fault", 32'h1, 32'(fault_pin_oe_o));
      @(posedge clk_i);
      rail_ilim_i <= 4'h0;
      ahb(1'b0, OFS_CAUSE, 32'h0);
      chk("cause", 32'h1, 32'(rd[CAUSE_OCP]));
      recover();
      @(posedge clk_i);
      frequency_set_pin_short_i <= 1'b1;
      @(posedge clk_i);
      frequency_set_pin_short_i <= 1'b0;
      @(negedge clk_i);
      chk("osc", 32'h1, 32'(osc_internal_o & fault_pin_oe_o));
      ahb(1'b0, OFS_STATUS, 32'h0);
      chk("count", 32'h5, 32'(rd[7:4]));
      stuck <= 4'h4;
      wait_en(4'h0);
      for (c = 0; c < 5000 && fault_pin_oe_o === 1'b1; c++) @(negedge clk_i);
      wait_en(4'h7);
      for (c = 0; c < 700 && fault_pin_oe_o !== 1'b1; c++) @(negedge clk_i);
      chk("timeout", 32'h1, 32'(c >= 485 && c <= 510 && rail_en_o === 4'h7));
      @(posedge clk_i);
      stuck <= 4'h0;
      recover();
      @(posedge clk_i);
      vin_ok_i <= 1'b0;
      @(posedge clk_i);
      vin_ok_i <= 1'b1;
      @(negedge clk_i);
      chk("rails", 32'h0, 32'({rail_en_o, fault_pin_oe_o}));
      ahb(1'b0, OFS_STATUS, 32'h0);
      chk("status", 32'h801, rd);
      ahb(1'b1, OFS_RETRY, 32'h1);
      ahb(1'b1, OFS_CTRL, 32'h1);
      run_up();
      switch_second_current_limit_i <= 1'b1;
      @(posedge clk_i);
      switch_second_current_limit_i <= 1'b0;
      repeat (300) @(negedge clk_i);
      ahb(1'b0, OFS_STATUS, 32'h0);
      chk("status", 32'h316, rd);
      enable_pin_i <= 1'b0;
      repeat (3) @(negedge clk_i);
      ahb(1'b0, OFS_STATUS, 32'h0);
      chk("status", 32'h801, rd);
      enable_pin_i <= 1'b1;
      run_up();
      enable_pin_i <= 1'b0;
      wait_en(4'h7);
      chk("fault", 32'h0, 32'(fault_pin_oe_o));
      wait_en(4'h0);
      ahb(1'b0, OFS_STATUS, 32'h0);
      chk("status", 32'h801, rd);
      wrap_up();
   end
endmodule : fault_supervisor_retry_sequencer_bench
